// ---- core/spc_defs.svh ----
// constants for the sleep and power control block: offsets, fields, resets and timing
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

// ****************************************************************
// register offsets (data space) and the i/o window
// ****************************************************************
`define SPC_SLEEP_MODE_CONTROL_ADDR 8'h53
`define SPC_CORE_MISC_CONTROL_ADDR 8'h55
`define SPC_PRR_ADDR 8'h64
`define SPC_IO_OFFSET 8'h20
`define SPC_IO_LIMIT 8'h3F

// ****************************************************************
// field positions
// ****************************************************************
`define SPC_SE_BIT 0
`define SPC_SM_LSB 1
`define SPC_SM_MSB 3
`define SPC_VECTOR_CHANGE_UNLOCK_BIT 0
`define SPC_VECTOR_TABLE_SELECT_BIT 1
`define SPC_PUD_BIT 4
`define SPC_BROWNOUT_SLEEP_UNLOCK_BIT 5
`define SPC_BROWNOUT_SLEEP_DISABLE_BIT 6
`define SPC_PRR_ADC 0
`define SPC_PRR_USART 1
`define SPC_PRR_SPI 2
`define SPC_PRR_TIM1 3
`define SPC_PRR_UNUSED 4
`define SPC_PRR_TIM0 5
`define SPC_PRR_TIM2 6
`define SPC_PRR_TWI 7

// ****************************************************************
// reset values and writable masks
// ****************************************************************
`define SPC_SLEEP_MODE_CONTROL_RESET 8'h00
`define SPC_CORE_MISC_CONTROL_RESET 8'h00
`define SPC_PRR_RESET 8'h00
`define SPC_SLEEP_MODE_CONTROL_MASK 8'h0F
`define SPC_PRR_MASK 8'hEF

// ****************************************************************
// mode select codes
// ****************************************************************
`define SPC_SM_IDLE 3'h0
`define SPC_SM_NOISE 3'h1
`define SPC_SM_PDOWN 3'h2
`define SPC_SM_PSAVE 3'h3
`define SPC_SM_STANDBY 3'h6
`define SPC_SM_XSTANDBY 3'h7

// ****************************************************************
// timing counts in clock cycles
// ****************************************************************
`define SPC_UNLOCK_CYCLES 3'h4
`define SPC_BROWNOUT_SLEEP_DISABLE_DELAY 3'h3
`define SPC_BROWNOUT_SLEEP_DISABLE_HOLD 3'h3
`define SPC_FAST_WAKE_CYCLES 16'h0006
`define SPC_STARTUP_CYCLES 16'h0010

`endif

// ---- core/spc_pkg.sv ----
// types shared by the sleep and power control block
package spc_pkg;
  // decoded sleep mode
  typedef enum logic [2:0] {
    spc_idle, spc_noise, spc_pdown, spc_psave, spc_standby, spc_xstandby, spc_reserved
  } spc_mode_t;
  // sleep sequencer state
  typedef enum logic [1:0] {
    spc_awake, spc_asleep, spc_waking
  } spc_state_t;
endpackage

// ---- core/spc_timer_if.sv ----
// control wires between the power controller and one unlock window timer
`timescale 1ns/1ps
interface spc_timer_if;
  logic start;
  logic clear;
  logic active;
  modport ctrl (output start, output clear, input active);
  modport timer (input start, input clear, output active);
endinterface

// ---- core/spc_window_timer.sv ----
// unlock window timer: open for a fixed count of cycles after a start pulse
`timescale 1ns/1ps
`include "spc_defs.svh"
module spc_window_timer (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // control from the power controller
  spc_timer_if.timer tmr
);
  logic [2:0] count;

  // a new start restarts the window; clear wins so an early close is never missed
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count <= 3'h0;
    end else if (tmr.clear) begin
      count <= 3'h0;
    end else if (tmr.start) begin
      count <= `SPC_UNLOCK_CYCLES;
    end else if (count != 3'h0) begin
      count <= count - 3'h1;
    end
  end

  assign tmr.active = (count != 3'h0);

  // ****************************************************************
  // checks
  // ****************************************************************
  a_window_len: assert property (@(posedge clock) disable iff (!resetn)
    (tmr.start && !tmr.clear) ##1 (!tmr.start && !tmr.clear)[*4] |=> !tmr.active)
    else $error("unlock window longer than four cycles");
endmodule // spc_window_timer

// ---- core/spc_sleep_power_control.sv ----
// sleep mode sequencer, peripheral clock gating and timed unlock control bits
`timescale 1ns/1ps
`include "spc_defs.svh"
module spc_sleep_power_control (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // core register access
  input wire logic bus_sel,
  input wire logic bus_we,
  input wire logic bus_io,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic bus_hit,
  // core sequencing
  input wire logic sleep_instr,
  input wire logic instr_done,
  input wire logic wake_event,
  output logic cpu_clk_en,
  output logic irq_mask,
  output logic [15:0] vector_base,
  // fuse configuration
  input wire logic xtal_selected,
  input wire logic debug_fuse_en,
  input wire logic brownout_level_fuses_en,
  input wire logic [15:0] boot_section_base,
  // clock domain enables
  output logic flash_clk_en,
  output logic io_clk_en,
  output logic adc_clk_en,
  output logic async_clk_en,
  output logic osc_en,
  // peripheral gating, bit order of the power reduction register
  output logic [7:0] periph_clk_en,
  output logic [7:0] periph_reg_block,
  // analog and safety blocks
  input wire logic adc_enable,
  input wire logic comparator_enable,
  input wire logic watchdog_enable,
  output logic adc_power_en,
  output logic comparator_power_en,
  output logic brownout_power_en,
  output logic watchdog_run,
  // port pins
  input wire logic [7:0] pin_direction_bit,
  input wire logic [7:0] pin_output_bit,
  input wire logic [7:0] wake_pin_mask,
  output logic [7:0] pullup_en,
  output logic [7:0] input_buffer_en,
  output logic pullup_global_off
);

  // ****************************************************************
  // register decode
  // ****************************************************************
  // io instructions see the same registers 0x20 lower; a miss maps to 0x00
  function automatic logic [7:0] spc_data_addr(input logic io, input logic [7:0] addr);
    if (!io) begin
      spc_data_addr = addr;
    end else if (addr <= `SPC_IO_LIMIT) begin
      spc_data_addr = addr + `SPC_IO_OFFSET;
    end else begin
      spc_data_addr = 8'h00;
    end
  endfunction

  function automatic spc_pkg::spc_mode_t spc_decode(input logic [2:0] code);
    case (code)
      `SPC_SM_IDLE: spc_decode = spc_pkg::spc_idle;
      `SPC_SM_NOISE: spc_decode = spc_pkg::spc_noise;
      `SPC_SM_PDOWN: spc_decode = spc_pkg::spc_pdown;
      `SPC_SM_PSAVE: spc_decode = spc_pkg::spc_psave;
      `SPC_SM_STANDBY: spc_decode = spc_pkg::spc_standby;
      `SPC_SM_XSTANDBY: spc_decode = spc_pkg::spc_xstandby;
      default: spc_decode = spc_pkg::spc_reserved;
    endcase
  endfunction

  logic [7:0] daddr;
  logic sleep_mode_control_wr;
  logic core_misc_control_wr;
  logic prr_wr;
  logic [7:0] sleep_mode_control;
  logic [7:0] power_reduction_reg;
  logic vector_table_select;
  logic brownout_sleep_disable;
  logic [2:0] brownout_sleep_disable_age;
  logic brownout_sleep_disable_active;
  logic bod_off_sleep;
  logic post_select;
  logic sleep_enable_bit;
  logic [2:0] sleep_mode_select;
  spc_pkg::spc_mode_t sel_mode;
  spc_pkg::spc_mode_t cur_mode;
  spc_pkg::spc_state_t state;
  logic [15:0] wake_cnt;
  logic take_sleep;
  logic fast_wake;
  logic asleep;
  logic deep;
  spc_timer_if brownout_sleep_disable_win ();
  spc_timer_if vector_change_unlock_win ();

  assign daddr = spc_data_addr(bus_io, bus_addr);
  assign sleep_mode_control_wr = bus_sel && bus_we && (daddr == `SPC_SLEEP_MODE_CONTROL_ADDR);
  assign core_misc_control_wr = bus_sel && bus_we && (daddr == `SPC_CORE_MISC_CONTROL_ADDR);
  assign prr_wr = bus_sel && bus_we && (daddr == `SPC_PRR_ADDR);
  assign sleep_enable_bit = sleep_mode_control[`SPC_SE_BIT];
  assign sleep_mode_select = sleep_mode_control[`SPC_SM_MSB:`SPC_SM_LSB];
  assign sel_mode = spc_decode(sleep_mode_select);

  // read data registered one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bus_rdata <= 8'h00;
      bus_hit <= 1'b0;
    end else if (bus_sel && !bus_we) begin
      if (daddr == `SPC_SLEEP_MODE_CONTROL_ADDR) begin
        bus_rdata <= sleep_mode_control;
        bus_hit <= 1'b1;
      end else if (daddr == `SPC_CORE_MISC_CONTROL_ADDR) begin
        bus_rdata <= {1'b0, brownout_sleep_disable, brownout_sleep_disable_win.active, pullup_global_off,
                      2'b00, vector_table_select, vector_change_unlock_win.active};
        bus_hit <= 1'b1;
      end else if (daddr == `SPC_PRR_ADDR) begin
        bus_rdata <= power_reduction_reg;
        bus_hit <= 1'b1;
      end else begin
        bus_rdata <= 8'h00;
        bus_hit <= 1'b0;
      end
    end else begin
      bus_rdata <= 8'h00;
      bus_hit <= 1'b0;
    end
  end

  // plain read/write control registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sleep_mode_control <= `SPC_SLEEP_MODE_CONTROL_RESET;
      power_reduction_reg <= `SPC_PRR_RESET;
      pullup_global_off <= 1'(`SPC_CORE_MISC_CONTROL_RESET >> `SPC_PUD_BIT);
    end else begin
      if (sleep_mode_control_wr) begin
        sleep_mode_control <= bus_wdata & `SPC_SLEEP_MODE_CONTROL_MASK;
      end
      if (prr_wr) begin
        power_reduction_reg <= bus_wdata & `SPC_PRR_MASK;
      end
      if (core_misc_control_wr) begin
        pullup_global_off <= bus_wdata[`SPC_PUD_BIT];
      end
    end
  end

  // ****************************************************************
  // brown-out sleep disable
  // ****************************************************************
  spc_window_timer u_brownout_sleep_disable_win (
    .clock(clock),
    .resetn(resetn),
    .tmr(brownout_sleep_disable_win)
  );

  // unlock write opens the window; any other write only touches other bits
  assign brownout_sleep_disable_win.start = core_misc_control_wr && bus_wdata[`SPC_BROWNOUT_SLEEP_DISABLE_BIT] && bus_wdata[`SPC_BROWNOUT_SLEEP_UNLOCK_BIT];
  assign brownout_sleep_disable_win.clear = 1'b0;

  // bit reads one for six cycles; only the last three can disarm the detector
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      brownout_sleep_disable <= 1'b0;
      brownout_sleep_disable_age <= 3'h0;
    end else if (core_misc_control_wr && bus_wdata[`SPC_BROWNOUT_SLEEP_DISABLE_BIT] && !bus_wdata[`SPC_BROWNOUT_SLEEP_UNLOCK_BIT] && brownout_sleep_disable_win.active) begin
      brownout_sleep_disable <= 1'b1;
      brownout_sleep_disable_age <= 3'h0;
    end else if (brownout_sleep_disable) begin
      if (brownout_sleep_disable_age == `SPC_BROWNOUT_SLEEP_DISABLE_DELAY + `SPC_BROWNOUT_SLEEP_DISABLE_HOLD - 3'h1) begin
        brownout_sleep_disable <= 1'b0;
      end
      brownout_sleep_disable_age <= brownout_sleep_disable_age + 3'h1;
    end
  end
  // a write outside the window never reaches the branch above
  assign brownout_sleep_disable_active = brownout_sleep_disable && (brownout_sleep_disable_age >= `SPC_BROWNOUT_SLEEP_DISABLE_DELAY);

  // ****************************************************************
  // interrupt vector relocation
  // ****************************************************************
  spc_window_timer u_vector_change_unlock_win (
    .clock(clock),
    .resetn(resetn),
    .tmr(vector_change_unlock_win)
  );

  assign vector_change_unlock_win.start = core_misc_control_wr && bus_wdata[`SPC_VECTOR_CHANGE_UNLOCK_BIT];
  assign vector_change_unlock_win.clear = core_misc_control_wr && !bus_wdata[`SPC_VECTOR_CHANGE_UNLOCK_BIT] && vector_change_unlock_win.active;

  // select changes only inside the window, with the unlock bit written as zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      vector_table_select <= 1'b0;
    end else if (vector_change_unlock_win.clear) begin
      vector_table_select <= bus_wdata[`SPC_VECTOR_TABLE_SELECT_BIT];
    end
  end

  // mask lasts through the instruction after the select write
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      post_select <= 1'b0;
    end else if (vector_change_unlock_win.clear) begin
      post_select <= 1'b1;
    end else if (instr_done) begin
      post_select <= 1'b0;
    end
  end

  // the status flag of the core is left alone; this only masks delivery
  assign irq_mask = vector_change_unlock_win.start || vector_change_unlock_win.active || post_select;
  assign vector_base = vector_table_select ? boot_section_base : 16'h0000;

  // ****************************************************************
  // sleep sequencer
  // ****************************************************************
  assign take_sleep = sleep_instr && sleep_enable_bit && (sel_mode != spc_pkg::spc_reserved);
  assign fast_wake = xtal_selected && ((cur_mode == spc_pkg::spc_standby) || (cur_mode == spc_pkg::spc_xstandby));

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= spc_pkg::spc_awake;
      cur_mode <= spc_pkg::spc_idle;
      wake_cnt <= 16'h0000;
    end else begin
      case (state)
        spc_pkg::spc_awake: begin
          if (take_sleep && state == spc_pkg::spc_awake) begin
            state <= spc_pkg::spc_asleep;
            cur_mode <= sel_mode;
          end
        end
        spc_pkg::spc_asleep: begin
          if (wake_event) begin
            state <= spc_pkg::spc_waking;
            wake_cnt <= fast_wake ? `SPC_FAST_WAKE_CYCLES - 16'h0001 : `SPC_STARTUP_CYCLES - 16'h0001;
          end
        end
        spc_pkg::spc_waking: begin
          if (wake_cnt == 16'h0000) begin
            state <= spc_pkg::spc_awake;
          end else begin
            wake_cnt <= wake_cnt - 16'h0001;
          end
        end
        default: begin
          state <= spc_pkg::spc_awake;
        end
      endcase
    end
  end

  // brown-out disarm is latched by the sleep that finds the bit active
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bod_off_sleep <= 1'b0;
    end else if (state == spc_pkg::spc_awake) begin
      bod_off_sleep <= take_sleep && brownout_sleep_disable_active;
    end
  end

  // ****************************************************************
  // clock domain and power outputs
  // ****************************************************************
  assign asleep = (state != spc_pkg::spc_awake);
  assign cpu_clk_en = !asleep;
  assign flash_clk_en = !asleep;
  assign io_clk_en = !asleep || (cur_mode == spc_pkg::spc_idle);
  assign adc_clk_en = io_clk_en || (cur_mode == spc_pkg::spc_noise);
  // timer 2 oscillator keeps running in the saving modes
  assign async_clk_en = adc_clk_en || (cur_mode == spc_pkg::spc_psave) || (cur_mode == spc_pkg::spc_xstandby);
  // without a crystal the standby codes stop the oscillator like the modes they copy
  assign osc_en = adc_clk_en || debug_fuse_en || fast_wake || (state == spc_pkg::spc_waking);
  assign deep = !io_clk_en && !adc_clk_en;

  // gating only narrows a running io clock; a cleared bit resumes frozen state
  assign periph_clk_en = {8{io_clk_en}} & ~power_reduction_reg & `SPC_PRR_MASK;
  assign periph_reg_block = power_reduction_reg;

  assign adc_power_en = adc_enable;
  assign comparator_power_en = comparator_enable && adc_clk_en;
  assign brownout_power_en = brownout_level_fuses_en && !(asleep && bod_off_sleep);
  assign watchdog_run = watchdog_enable;
  assign input_buffer_en = deep ? wake_pin_mask : 8'hFF;
  assign pullup_en = ~pin_direction_bit & pin_output_bit & {8{!pullup_global_off}};

  // ****************************************************************
  // checks
  // ****************************************************************
  a_sleep_gated: assert property (@(posedge clock) disable iff (!resetn)
    (state == spc_pkg::spc_awake && sleep_instr && !sleep_enable_bit) |=> (state == spc_pkg::spc_awake))
    else $error("sleep taken without enable");
  a_reserved_ignored: assert property (@(posedge clock) disable iff (!resetn)
    (state == spc_pkg::spc_awake && sel_mode == spc_pkg::spc_reserved) |=> !asleep)
    else $error("reserved mode entered");
  a_fast_wake: assert property (@(posedge clock) disable iff (!resetn)
    (state == spc_pkg::spc_asleep && wake_event && fast_wake) |-> (!cpu_clk_en)[*7] ##1 cpu_clk_en)
    else $error("standby wake not six cycles");
  a_gate_follows: assert property (@(posedge clock) disable iff (!resetn)
    prr_wr |=> (periph_reg_block == $past(bus_wdata & `SPC_PRR_MASK)))
    else $error("gate bits not stored");
  a_deep_gated: assert property (@(posedge clock) disable iff (!resetn)
    (asleep && cur_mode != spc_pkg::spc_idle) |-> (periph_clk_en == 8'h00))
    else $error("peripheral clock runs in deep sleep");
  a_comp_off: assert property (@(posedge clock) disable iff (!resetn)
    (asleep && (cur_mode == spc_pkg::spc_pdown || cur_mode == spc_pkg::spc_standby)) |-> !comparator_power_en)
    else $error("comparator left on");
  a_bod_kept: assert property (@(posedge clock) disable iff (!resetn)
    (brownout_level_fuses_en && !bod_off_sleep) |-> brownout_power_en)
    else $error("brown-out dropped without disable");
  a_brownout_sleep_disable_timing: assert property (@(posedge clock) disable iff (!resetn)
    ($rose(brownout_sleep_disable) && !core_misc_control_wr) ##1 (!core_misc_control_wr)[*5] |->
    ($past(brownout_sleep_disable_active, 2) && !$past(brownout_sleep_disable_active, 3)) ##1 !brownout_sleep_disable)
    else $error("brown-out disable timing wrong");
  a_brownout_sleep_disable_ignored: assert property (@(posedge clock) disable iff (!resetn)
    (core_misc_control_wr && !brownout_sleep_disable_win.active && !brownout_sleep_disable && !bus_wdata[`SPC_BROWNOUT_SLEEP_UNLOCK_BIT]) |=> !brownout_sleep_disable)
    else $error("untimed brown-out disable accepted");
  a_vector_change_unlock_expire: assert property (@(posedge clock) disable iff (!resetn)
    ($rose(vector_change_unlock_win.active) && !core_misc_control_wr) ##1 (!core_misc_control_wr)[*3] |=> !vector_change_unlock_win.active)
    else $error("vector unlock not cleared");
  a_irq_masked: assert property (@(posedge clock) disable iff (!resetn)
    $fell(vector_change_unlock_win.active) && $past(vector_change_unlock_win.clear) |-> irq_mask)
    else $error("interrupts unmasked right after select write");
  a_inbuf_off: assert property (@(posedge clock) disable iff (!resetn)
    (asleep && cur_mode == spc_pkg::spc_pdown) |-> (input_buffer_en == wake_pin_mask))
    else $error("input buffers on in deep sleep");
  a_osc_debug: assert property (@(posedge clock) disable iff (!resetn)
    debug_fuse_en |-> osc_en)
    else $error("oscillator stopped with debug");
  c_standby_wake: cover property (@(posedge clock) disable iff (!resetn)
    state == spc_pkg::spc_asleep && fast_wake && wake_event);
  c_bod_disarmed: cover property (@(posedge clock) disable iff (!resetn)
    asleep && !brownout_power_en && brownout_level_fuses_en);
  c_vector_moved: cover property (@(posedge clock) disable iff (!resetn)
    $rose(vector_table_select));
endmodule // spc_sleep_power_control

// ---- tb/spc_core_model.sv ----
// core-side model: register accesses, sleep instruction and instruction completion
`timescale 1ns/1ps
module spc_core_model (
  // clock
  input wire logic clock,
  // register access
  output logic bus_sel,
  output logic bus_we,
  output logic bus_io,
  output logic [7:0] bus_addr,
  output logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_hit,
  // sequencing
  output logic sleep_instr,
  output logic instr_done
);
  // the core is idle until the bench asks for something
  initial begin
    bus_sel = 1'b0;
    bus_we = 1'b0;
    bus_io = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
    sleep_instr = 1'b0;
    instr_done = 1'b0;
  end
  // one access per call, with one idle cycle between calls, so two-step unlock writes land inside the window
  task automatic acc(input logic io, input logic we, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] rd, output logic hit);
    @(posedge clock);
    bus_sel <= 1'b1;
    bus_we <= we;
    bus_io <= io;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clock);
    bus_sel <= 1'b0;
    @(negedge clock);
    rd = bus_rdata;
    hit = bus_hit;
  endtask
  // one-cycle pulse: sleep instruction when s is set, else an instruction completing
  task automatic pulse(input logic s);
    @(posedge clock);
    sleep_instr <= s;
    instr_done <= !s;
    @(posedge clock);
    sleep_instr <= 1'b0;
    instr_done <= 1'b0;
  endtask
endmodule // spc_core_model

// ---- tb/sleep_power_control_tb_top.sv ----
// testbench: register map, sleep modes, gating and the timed unlock sequences
`timescale 1ns/1ps
module sleep_power_control_tb_top;
  logic [15:0] boot_section_base = 16'h1c00; // arbitrary boot base
  logic clock = 0;
  logic resetn = 0;
  logic wake_event = 0;
  logic xtal_selected = 1;
  logic debug_fuse_en = 0;
  logic brownout_level_fuses_en = 1;
  logic adc_enable = 1;
  logic comparator_enable = 1;
  logic watchdog_enable = 1;
  logic [7:0] pin_direction_bit = 8'h00;
  logic [7:0] pin_output_bit = 8'hff;
  logic [7:0] wake_pin_mask = 8'h05;
  logic bus_sel, bus_we, bus_io, bus_hit, sleep_instr, instr_done, hit;
  logic [7:0] bus_addr, bus_wdata, bus_rdata, periph_clk_en, periph_reg_block, pullup_en, input_buffer_en, rd;
  logic cpu_clk_en, irq_mask, flash_clk_en, io_clk_en, adc_clk_en, async_clk_en, osc_en, pullup_global_off;
  logic adc_power_en, comparator_power_en, brownout_power_en, watchdog_run;
  logic [15:0] vector_base;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  spc_sleep_power_control dut (.*);
  spc_core_model core (.*);
  // 200 MHz clock
  always #2.5 clock = ~clock;
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures = failures + 1;
      finish_test();
    end
  end
  // ****
  // helpers
  // ****
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
    core.acc(io, 1'b1, a, d, rd, hit);
  endtask
  task automatic rdchk(input logic io, input logic [7:0] a, input logic [7:0] e, input logic eh);
    core.acc(io, 1'b0, a, 8'h00, rd, hit);
    chk(rd, e);
    chk(hit, eh);
  endtask
  // raise a wake condition and count edges until the core clock returns
  task automatic wake;
    @(posedge clock);
    wake_event <= 1'b1;
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    wake_event <= 1'b0;
  endtask
  task automatic finish_test;
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_regs;
    rdchk(0, 8'h53, 8'h00, 1);
    rdchk(0, 8'h64, 8'h00, 1);
    rdchk(0, 8'h60, 8'h00, 0);
    wr(1, 8'h33, 8'h0c);
    rdchk(0, 8'h53, 8'h0c, 1);
    rdchk(1, 8'h35, 8'h00, 1);
    wr(0, 8'h64, 8'hff);
    rdchk(0, 8'h64, 8'hef, 1);
    chk(periph_clk_en, 8'h00);
    chk(periph_reg_block, 8'hef);
    wr(0, 8'h64, 8'h00);
    chk(periph_clk_en, 8'hef);
    chk(pullup_en, 8'hff);
    wr(1, 8'h35, 8'h10);
    chk({pullup_global_off, pullup_en}, 9'h100);
    wr(1, 8'h35, 8'h00);
  endtask
  // sleep with the enable clear, then with a reserved code, must leave the core running
  task automatic t_nosleep;
    wr(0, 8'h53, 8'h04);
    core.pulse(1);
    @(negedge clock);
    chk(cpu_clk_en, 1);
    wr(0, 8'h53, 8'h09);
    core.pulse(1);
    @(negedge clock);
    chk(cpu_clk_en, 1);
  endtask
  task automatic t_mode(input logic [2:0] m, input logic dbg, input logic xt);
    logic fast, deep;
    fast = m[2] & m[1] & xt;
    deep = m[1];
    debug_fuse_en <= dbg;
    xtal_selected <= xt;
    wr(0, 8'h53, {4'h0, m, 1'b1});
    core.pulse(1);
    @(negedge clock);
    chk(cpu_clk_en, 0);
    chk(osc_en, !deep | fast | dbg);
    chk(comparator_power_en, !deep);
    chk(input_buffer_en, deep ? wake_pin_mask : 8'hff);
    chk(periph_clk_en, m == 3'h0 ? 8'hef : 8'h00);
    chk({adc_power_en, watchdog_run, brownout_power_en}, 3'h7);
    wake();
    chk(n <= 8, fast);
    wr(0, 8'h53, 8'h00);
  endtask
  // fuse and enable inputs pass straight through or gate their outputs
  task automatic t_pass;
    @(posedge clock);
    adc_enable <= 1'b0;
    watchdog_enable <= 1'b0;
    comparator_enable <= 1'b0;
    brownout_level_fuses_en <= 1'b0;
    pin_direction_bit <= 8'h0f;
    @(negedge clock);
    chk({adc_power_en, watchdog_run, comparator_power_en, brownout_power_en}, 4'h0);
    chk(pullup_en, 8'hf0);
    @(posedge clock);
    adc_enable <= 1'b1;
    watchdog_enable <= 1'b1;
    comparator_enable <= 1'b1;
    brownout_level_fuses_en <= 1'b1;
    pin_direction_bit <= 8'h00;
    @(negedge clock);
    chk({adc_power_en, watchdog_run, comparator_power_en, brownout_power_en}, 4'hf);
  endtask
  task automatic t_bod;
    wr(0, 8'h53, 8'h05);
    wr(0, 8'h55, 8'h40);
    rdchk(0, 8'h55, 8'h00, 1);
    wr(0, 8'h55, 8'h60);
    wr(0, 8'h55, 8'h40);
    repeat (3) @(posedge clock);
    core.pulse(1);
    @(negedge clock);
    chk(brownout_power_en, 0);
    wake();
    chk(brownout_power_en, 1);
    rdchk(0, 8'h55, 8'h00, 1);
    core.pulse(1);
    @(negedge clock);
    chk(brownout_power_en, 1);
    wake();
  endtask
  task automatic t_vec;
    chk(vector_base, 16'h0000);
    wr(1, 8'h35, 8'h01);
    chk(irq_mask, 1);
    wr(1, 8'h35, 8'h02);
    chk(vector_base, boot_section_base);
    chk(irq_mask, 1);
    core.pulse(0);
    @(negedge clock);
    chk(irq_mask, 0);
    wr(1, 8'h35, 8'h01);
    rdchk(1, 8'h35, 8'h03, 1);
    repeat (6) @(negedge clock);
    chk(irq_mask, 0);
    rdchk(1, 8'h35, 8'h02, 1);
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    t_regs();
    t_nosleep();
    t_pass();
    foreach (codes[i]) t_mode(codes[i], 1'b0, 1'b1);
    t_mode(3'h2, 1'b1, 1'b1);
    t_mode(3'h6, 1'b0, 1'b0);
    t_bod();
    t_vec();
    finish_test();
  end
endmodule // sleep_power_control_tb_top
